// *** rtl/fcs_top.sv ***
// Clock source unit: source select, dividers, mode control and Wishbone registers
//
// Local design decisions: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
module fcs_top
	import fcs_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_b_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [4:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        stop_req_i,
	input  wire logic        loop_clk_i,
	input  wire logic        int_ref_clk_i,
	input  wire logic        ext_ref_clk_i,
	input  wire logic        xtal_ready_i,
	output logic             system_clock_out_o,
	output logic             bus_clk_o,
	output logic             int_ref_clock_out_o,
	output logic             ext_ref_clock_out_o,
	output logic             int_ref_enable_o,
	output logic             ext_ref_enable_o,
	output logic             loop_enable_o,
	output logic             loop_ref_clk_o,
	output logic             loop_locked_o,
	output logic [8:0]       int_ref_trim_o,
	output logic             freq_range_o,
	output logic             high_gain_select_o,
	output logic             ext_ref_type_select_o,
	output logic             ext_ref_output_enable_o,
	output logic             ext_ref_stop_enable_o
);
	function automatic logic [1:0] src_of(input logic [1:0] sel);
		src_of = (sel == SRC_EXT || sel == SRC_INT) ? sel : SRC_LOOP;
	endfunction

	function automatic logic pick_div(input logic lvl, input logic [DIV_W-1:0] cnt,
		input logic [2:0] code);
		pick_div = (code == 3'h0) ? lvl : cnt[code - 3'h1];
	endfunction

	logic [7:0]  ctrl_one_ff;
	logic [7:0]  ctrl_two_ff;
	logic [7:0]  trim_ff;
	logic        fine_trim_ff;
	logic        xtal_done_ff;
	logic        ack_ff;
	logic [31:0] rdat_ff;
	logic [1:0]  cur_src_ff;
	logic [1:0]  tgt_src_ff;
	fcs_sw_t     sw_ff;
	fcs_mode_t   mode_ff;
	fcs_mode_t   pre_stop_ff;
	logic [3:0]  lvl_d_ff;
	logic        sys_out_ff;
	logic        bus_clk_ff;
	logic        ref_out_ff;
	logic        int_out_ff;
	logic        ext_out_ff;
	logic        locked_ff;
	logic [LOOP_CNT_W-1:0] loop_cnt_ff;

	// Pin levels: [0] loop, [1] internal, [2] external, [3] crystal ready
	logic [3:0]  lvl;
	logic [3:0]  rise;
	logic [3:0]  fall;
	fcs_sync2 #(.W(4)) u_sync (
		.clk_i   (clk_i),
		.rst_b_i (rst_b_i),
		.d_i     ({xtal_ready_i, ext_ref_clk_i, int_ref_clk_i, loop_clk_i}),
		.q_o     (lvl)
	);
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			lvl_d_ff <= '0;
		end else begin
			lvl_d_ff <= lvl;
		end
	end
	assign rise = lvl & ~lvl_d_ff;
	assign fall = ~lvl & lvl_d_ff;

	// Field decode
	wire [1:0] system_clock_select     = ctrl_one_ff[SYSTEM_CLOCK_SELECT_HI:SYSTEM_CLOCK_SELECT_LO];
	wire [2:0] loop_ref_divider     = ctrl_one_ff[LOOP_REF_DIVIDER_HI:LOOP_REF_DIVIDER_LO];
	wire       loop_ref_select    = ctrl_one_ff[LOOP_REF_SELECT_BIT];
	wire       int_ref_output_enable  = ctrl_one_ff[INT_REF_OUTPUT_ENABLE_BIT];
	wire       int_ref_stop_enable = ctrl_one_ff[INT_REF_STOP_ENABLE_BIT];
	wire [1:0] bus_divider     = ctrl_two_ff[BUS_DIVIDER_HI:BUS_DIVIDER_LO];
	wire       lp       = ctrl_two_ff[LP_BIT];
	wire       ext_ref_type_select    = ctrl_two_ff[EXT_REF_TYPE_SELECT_BIT];
	wire       ext_ref_output_enable  = ctrl_two_ff[EXT_REF_OUTPUT_ENABLE_BIT];
	wire       ext_ref_stop_enable = ctrl_two_ff[EXT_REF_STOP_ENABLE_BIT];
	wire [1:0] req_src  = src_of(system_clock_select);

	// Requested mode from the select, loop reference and low power bits
	fcs_mode_t nxt_mode;
	always_comb begin
		nxt_mode = FCS_FEI;
		if (stop_req_i) begin
			nxt_mode = FCS_STOP;
		end else begin
			case (req_src)
				SRC_LOOP: nxt_mode = loop_ref_select ? FCS_FEI : FCS_FEE;
				SRC_INT:  nxt_mode = lp ? FCS_BYPASS_INTERNAL_LOW_POWER_MODE : FCS_FBI;
				SRC_EXT:  nxt_mode = lp ? FCS_BYPASS_EXTERNAL_LOW_POWER_MODE : FCS_FBE;
				default:  nxt_mode = FCS_FEI;
			endcase
		end
	end

	wire in_stop   = (mode_ff == FCS_STOP);
	wire int_mode  = (pre_stop_ff == FCS_FEI) || (pre_stop_ff == FCS_FBI)
		|| (pre_stop_ff == FCS_BYPASS_INTERNAL_LOW_POWER_MODE);
	wire ext_mode  = (pre_stop_ff == FCS_FEE) || (pre_stop_ff == FCS_FBE)
		|| (pre_stop_ff == FCS_BYPASS_EXTERNAL_LOW_POWER_MODE);
	wire loop_on   = !in_stop && !(lp && req_src != SRC_LOOP);
	wire int_need  = (loop_on && loop_ref_select) || (req_src == SRC_INT) || int_ref_output_enable;
	wire ext_need  = (loop_on && !loop_ref_select) || (req_src == SRC_EXT) || ext_ref_output_enable;
	wire int_en    = in_stop ? (int_ref_stop_enable && (int_ref_output_enable || int_mode)) : int_need;
	wire ext_en    = in_stop ? (ext_ref_stop_enable && (ext_ref_output_enable || ext_mode)) : ext_need;
	wire ext_used  = ext_ref_output_enable || (!in_stop && ext_need && !loop_ref_select)
		|| (!in_stop && req_src == SRC_EXT);

	// Loop reference: select and divide by two to the field power
	wire       ref_lvl  = loop_ref_select ? lvl[1] : lvl[2];
	wire       ref_rise = loop_ref_select ? rise[1] : rise[2];
	logic [DIV_W-1:0] ref_cnt;
	fcs_edge_cnt #(.W(DIV_W)) u_ref_div (
		.clk_i   (clk_i),
		.rst_b_i (rst_b_i),
		.clear_i (!loop_on),
		.tick_i  (ref_rise),
		.cnt_o   (ref_cnt)
	);
	wire nxt_ref_out = loop_on && pick_div(ref_lvl, ref_cnt, loop_ref_divider);

	// Lock check: loop edges counted over one divided reference period
	wire ref_out_rise = nxt_ref_out && !ref_out_ff;
	wire [LOOP_CNT_W-1:0] nxt_loop_cnt = ref_out_rise ? '0 :
		(rise[0] && loop_cnt_ff != LOOP_CNT_MAX) ? LOOP_CNT_W'(loop_cnt_ff + 1'b1) :
		loop_cnt_ff;

	// Selected source and bus divider
	logic       src_lvl;
	logic       src_rise;
	logic       src_fall;
	logic       tgt_rise;
	always_comb begin
		src_lvl  = lvl[cur_src_ff];
		src_rise = rise[cur_src_ff];
		src_fall = fall[cur_src_ff];
		tgt_rise = rise[tgt_src_ff];
	end
	logic [DIV_W-1:0] out_cnt;
	fcs_edge_cnt #(.W(DIV_W)) u_bus_div (
		.clk_i   (clk_i),
		.rst_b_i (rst_b_i),
		.clear_i (sw_ff != FCS_SW_IDLE),
		.tick_i  (src_rise),
		.cnt_o   (out_cnt)
	);
	wire nxt_sys_out = !in_stop && sw_ff == FCS_SW_IDLE
		&& pick_div(src_lvl, out_cnt, {1'b0, bus_divider});

	// Source switch: park low as soon as the switch leaves idle, hand over once old source is low, resume on new source rise
	fcs_sw_t nxt_sw;
	always_comb begin
		nxt_sw = sw_ff;
		case (sw_ff)
			FCS_SW_IDLE: nxt_sw = (req_src != cur_src_ff) ? FCS_SW_OLD : FCS_SW_IDLE;
			FCS_SW_OLD:  nxt_sw = (!sys_out_ff && (src_fall || !src_lvl)) ?
				FCS_SW_NEW : FCS_SW_OLD;
			FCS_SW_NEW:  nxt_sw = tgt_rise ? FCS_SW_IDLE : FCS_SW_NEW;
			default:     nxt_sw = FCS_SW_IDLE;
		endcase
	end

	// Bus slave
	wire        req     = wb_cyc_i && wb_stb_i && !ack_ff;
	wire        wr_lane = req && wb_we_i && wb_sel_i[0];
	wire        wr_c1   = wr_lane && wb_adr_i == ADDR_CTRL_ONE;
	wire        wr_c2   = wr_lane && wb_adr_i == ADDR_CTRL_TWO;
	wire        wr_tr   = wr_lane && wb_adr_i == ADDR_TRIM;
	wire        wr_sc   = wr_lane && wb_adr_i == ADDR_STAT_FT;
	wire [7:0]  stat_rd = {4'h0, cur_src_ff, xtal_done_ff, fine_trim_ff};
	logic [7:0] rd_byte;
	always_comb begin
		case (wb_adr_i)
			ADDR_CTRL_ONE:  rd_byte = ctrl_one_ff;
			ADDR_CTRL_TWO:  rd_byte = ctrl_two_ff;
			ADDR_TRIM:      rd_byte = trim_ff;
			ADDR_STAT_FT:   rd_byte = stat_rd;
			ADDR_LOOP_STAT: rd_byte = {4'h0, mode_ff, locked_ff};
			default:        rd_byte = 8'h00;
		endcase
	end

	// Crystal startup flag: setting wins over clearing
	wire xtal_set   = ext_ref_type_select && ext_used && lvl[3];
	wire xtal_clr   = !ext_ref_type_select || !ext_ref_output_enable;
	wire nxt_xtal   = xtal_set || (xtal_done_ff && !xtal_clr);

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ctrl_one_ff  <= CTRL_ONE_RST;
			ctrl_two_ff  <= CTRL_TWO_RST;
			trim_ff      <= TRIM_RST;
			fine_trim_ff <= FT_RST;
			ack_ff       <= 1'b0;
			rdat_ff      <= '0;
		end else begin
			ack_ff  <= req;
			rdat_ff <= req ? {24'h000000, rd_byte} : rdat_ff;
			if (wr_c1) ctrl_one_ff <= wb_dat_i[7:0];
			if (wr_c2) ctrl_two_ff <= wb_dat_i[7:0];
			if (wr_tr) trim_ff <= wb_dat_i[7:0];
			if (wr_sc) fine_trim_ff <= wb_dat_i[0];
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			mode_ff      <= FCS_FEI;
			pre_stop_ff  <= FCS_FEI;
			sw_ff        <= FCS_SW_IDLE;
			cur_src_ff   <= SRC_LOOP;
			tgt_src_ff   <= SRC_LOOP;
			xtal_done_ff <= 1'b0;
		end else begin
			mode_ff      <= nxt_mode;
			pre_stop_ff  <= in_stop ? pre_stop_ff : mode_ff;
			sw_ff        <= nxt_sw;
			tgt_src_ff   <= (sw_ff == FCS_SW_IDLE) ? req_src : tgt_src_ff;
			cur_src_ff   <= (sw_ff == FCS_SW_NEW && tgt_rise) ? tgt_src_ff : cur_src_ff;
			xtal_done_ff <= nxt_xtal;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sys_out_ff  <= 1'b0;
			bus_clk_ff  <= 1'b0;
			ref_out_ff  <= 1'b0;
			int_out_ff  <= 1'b0;
			ext_out_ff  <= 1'b0;
			locked_ff   <= 1'b0;
			loop_cnt_ff <= '0;
		end else begin
			sys_out_ff  <= nxt_sys_out;
			bus_clk_ff  <= (nxt_sys_out && !sys_out_ff) ? !bus_clk_ff : bus_clk_ff;
			ref_out_ff  <= nxt_ref_out;
			int_out_ff  <= int_ref_output_enable && int_en && lvl[1];
			ext_out_ff  <= ext_ref_output_enable && ext_en && lvl[2];
			loop_cnt_ff <= nxt_loop_cnt;
			locked_ff   <= !loop_on ? 1'b0 :
				(ref_out_rise ? (loop_cnt_ff == LOOP_MULT) : locked_ff);
		end
	end

	assign wb_ack_o                = ack_ff;
	assign wb_dat_o                = rdat_ff;
	assign system_clock_out_o      = sys_out_ff;
	assign bus_clk_o               = bus_clk_ff;
	assign int_ref_clock_out_o     = int_out_ff;
	assign ext_ref_clock_out_o     = ext_out_ff;
	assign int_ref_enable_o        = int_en;
	assign ext_ref_enable_o        = ext_en;
	assign loop_enable_o           = loop_on;
	assign loop_ref_clk_o          = ref_out_ff;
	assign loop_locked_o           = locked_ff;
	assign int_ref_trim_o          = {trim_ff, fine_trim_ff};
	assign freq_range_o            = ctrl_two_ff[RANGE_BIT];
	assign high_gain_select_o      = ctrl_two_ff[HGO_BIT];
	assign ext_ref_type_select_o   = ext_ref_type_select;
	assign ext_ref_output_enable_o = ext_ref_output_enable;
	assign ext_ref_stop_enable_o   = ext_ref_stop_enable;
endmodule

// *** rtl/fcs_pkg.sv ***
// Package: register map, field layout, reset values and modes of the clock source unit
package fcs_pkg;
	localparam int          WB_AW          = 5;
	localparam logic [4:0]  ADDR_CTRL_ONE  = 5'h00;
	localparam logic [4:0]  ADDR_CTRL_TWO  = 5'h04;
	localparam logic [4:0]  ADDR_TRIM      = 5'h08;
	localparam logic [4:0]  ADDR_STAT_FT   = 5'h0c;
	localparam logic [4:0]  ADDR_LOOP_STAT = 5'h10;

	localparam logic [7:0]  CTRL_ONE_RST   = 8'h04;
	localparam logic [7:0]  CTRL_TWO_RST   = 8'h40;
	localparam logic [7:0]  TRIM_RST       = 8'h80;
	localparam logic        FT_RST         = 1'b0;

	// Control one fields
	localparam int          SYSTEM_CLOCK_SELECT_HI        = 7;
	localparam int          SYSTEM_CLOCK_SELECT_LO        = 6;
	localparam int          LOOP_REF_DIVIDER_HI        = 5;
	localparam int          LOOP_REF_DIVIDER_LO        = 3;
	localparam int          LOOP_REF_SELECT_BIT      = 2;
	localparam int          INT_REF_OUTPUT_ENABLE_BIT    = 1;
	localparam int          INT_REF_STOP_ENABLE_BIT   = 0;
	// Control two fields
	localparam int          BUS_DIVIDER_HI        = 7;
	localparam int          BUS_DIVIDER_LO        = 6;
	localparam int          RANGE_BIT      = 5;
	localparam int          HGO_BIT        = 4;
	localparam int          LP_BIT         = 3;
	localparam int          EXT_REF_TYPE_SELECT_BIT      = 2;
	localparam int          EXT_REF_OUTPUT_ENABLE_BIT    = 1;
	localparam int          EXT_REF_STOP_ENABLE_BIT   = 0;

	localparam int          DIV_W          = 7;
	localparam int          LOOP_CNT_W     = 11;
	localparam logic [10:0] LOOP_MULT      = 11'h200;
	localparam logic [10:0] LOOP_CNT_MAX   = 11'h7ff;

	localparam logic [1:0]  SRC_LOOP       = 2'h0;
	localparam logic [1:0]  SRC_INT        = 2'h1;
	localparam logic [1:0]  SRC_EXT        = 2'h2;

	typedef enum logic [2:0] {
		FCS_FEI, FCS_FEE, FCS_FBI, FCS_BYPASS_INTERNAL_LOW_POWER_MODE, FCS_FBE, FCS_BYPASS_EXTERNAL_LOW_POWER_MODE, FCS_STOP
	} fcs_mode_t;

	typedef enum logic [1:0] {
		FCS_SW_IDLE, FCS_SW_OLD, FCS_SW_NEW
	} fcs_sw_t;
endpackage

// *** rtl/fcs_prims.sv ***
// Small helpers: multi-bit two-flop synchroniser and an edge counter
`timescale 1ns/1ps
module fcs_sync2 #(
	parameter int W = 4
) (
	input  wire logic         clk_i,
	input  wire logic         rst_b_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] q_ff;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			meta_ff <= '0;
			q_ff    <= '0;
		end else begin
			meta_ff <= d_i;
			q_ff    <= meta_ff;
		end
	end
	assign q_o = q_ff;
endmodule

module fcs_edge_cnt #(
	parameter int W = 7
) (
	input  wire logic         clk_i,
	input  wire logic         rst_b_i,
	input  wire logic         clear_i,
	input  wire logic         tick_i,
	output logic      [W-1:0] cnt_o
);
	logic [W-1:0] cnt_ff;
	logic [W-1:0] nxt_cnt;

	assign nxt_cnt = clear_i ? '0 : (tick_i ? W'(cnt_ff + 1'b1) : cnt_ff);

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_ff <= '0;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end
	assign cnt_o = cnt_ff;
endmodule

// *** sim/fcs_top_assertions.sv ***
// Checker of bus answers, clock output, stop and trim relations at the unit's ports
`timescale 1ns/1ps
module fcs_top_assertions
	import fcs_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        rst_b_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [4:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        stop_req_i,
	input wire logic        system_clock_out_o,
	input wire logic        bus_clk_o,
	input wire logic        loop_enable_o,
	input wire logic [8:0]  int_ref_trim_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("no ack after request");
	AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack wider than one cycle");
	AST_RD_UPPER: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0)
		else $error("read upper bits set");
	AST_RD_UNMAPPED: assert property (wb_ack_o && !wb_we_i && wb_adr_i > ADDR_LOOP_STAT
		|-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
	AST_TRIM_WR: assert property (
		wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == ADDR_TRIM
		|=> int_ref_trim_o[8:1] == $past(wb_dat_i[7:0])) else $error("trim not applied");
	AST_RESET_STATE: assert property (
		$rose(rst_b_i) |-> loop_enable_o && int_ref_trim_o == 9'h100)
		else $error("wrong state after reset");
	AST_STOP_LOOP: assert property (stop_req_i [*3] |-> !loop_enable_o)
		else $error("loop running in stop");
	AST_BUS_HALF: assert property ($changed(bus_clk_o) |-> system_clock_out_o)
		else $error("bus clock moved while system clock low");
endmodule

bind fcs_top fcs_top_assertions fcs_top_assertions_i (.clk_i(clk_i), .rst_b_i(rst_b_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.stop_req_i(stop_req_i), .system_clock_out_o(system_clock_out_o),
	.bus_clk_o(bus_clk_o), .loop_enable_o(loop_enable_o), .int_ref_trim_o(int_ref_trim_o));

// *** sim/fcs_partner.sv ***
// Far side: source clocks and crystal driver start-up
`timescale 1ns/1ps
module fcs_partner #(
	parameter int XTAL_INIT = 16
) (
	input  wire logic loop_enable_i,
	input  wire logic int_ref_enable_i,
	input  wire logic ext_ref_enable_i,
	output logic      loop_clk_o,
	output logic      int_ref_clk_o,
	output logic      ext_ref_clk_o,
	output logic      xtal_ready_o
);
	int n = 0;

	// Each source stands low while disabled
	initial begin
		{loop_clk_o, int_ref_clk_o, ext_ref_clk_o} = 3'h0;
		fork
			forever #230 loop_clk_o = loop_enable_i & ~loop_clk_o;
			forever #700 int_ref_clk_o = int_ref_enable_i & ~int_ref_clk_o;
			forever #1100 ext_ref_clk_o = ext_ref_enable_i & ~ext_ref_clk_o;
		join
	end
	// Crystal reports ready after its start-up edges
	always @(posedge ext_ref_clk_o or negedge ext_ref_enable_i)
		n = !ext_ref_enable_i ? 0 : n + int'(n < XTAL_INIT);
	assign xtal_ready_o = ext_ref_enable_i && n >= XTAL_INIT;
endmodule

// *** sim/fcs_top_bench.sv ***
// Bench: registers, modes, dividers, stop and crystal flag of the clock source unit
`timescale 1ns/1ps
module fcs_top_bench;
	import fcs_pkg::*;
	logic        clk_i, rst_b_i, cyc, stb, we, stop, sc, bc, ir, er, ie, ee, le, lc, ic, ec, xr;
	logic        ack, p_rng, p_hgo, p_ext_ref_type_select, p_eren, p_erst, lk;
	logic [4:0]  adr;
	logic [3:0]  sel;
	logic [31:0] di, dout, v;
	logic [8:0]  trim;
	logic [7:0]  exp_q[$], msk_q[$];
	logic [31:0] seed = 32'h3b8;
	int          n_mismatch, compares, nr, ns, nb, ni, ne;
	logic [7:0]  c1[7] = '{8'h04, 8'h00, 8'h44, 8'h44, 8'h84, 8'h84, 8'hc4};
	logic [7:0]  c2[7] = '{8'h42, 8'h42, 8'h42, 8'h4a, 8'h42, 8'h4a, 8'h42};
	logic [1:0]  sr[7] = '{SRC_LOOP, SRC_LOOP, SRC_INT, SRC_INT, SRC_EXT, SRC_EXT, SRC_LOOP};
	fcs_mode_t   md[7] = '{FCS_FEI, FCS_FEE, FCS_FBI, FCS_BYPASS_INTERNAL_LOW_POWER_MODE, FCS_FBE, FCS_BYPASS_EXTERNAL_LOW_POWER_MODE, FCS_FEI};

	fcs_top fcs_top_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(di), .wb_dat_o(dout),
		.wb_ack_o(ack), .stop_req_i(stop), .loop_clk_i(lc), .int_ref_clk_i(ic),
		.ext_ref_clk_i(ec), .xtal_ready_i(xr), .system_clock_out_o(sc), .bus_clk_o(bc),
		.int_ref_clock_out_o(ir), .ext_ref_clock_out_o(er), .int_ref_enable_o(ie),
		.ext_ref_enable_o(ee), .loop_enable_o(le), .loop_ref_clk_o(), .loop_locked_o(lk),
		.int_ref_trim_o(trim), .freq_range_o(p_rng), .high_gain_select_o(p_hgo),
		.ext_ref_type_select_o(p_ext_ref_type_select), .ext_ref_output_enable_o(p_eren),
		.ext_ref_stop_enable_o(p_erst));
	fcs_partner fcs_partner_i (.loop_enable_i(le), .int_ref_enable_i(ie),
		.ext_ref_enable_i(ee), .loop_clk_o(lc), .int_ref_clk_o(ic), .ext_ref_clk_o(ec),
		.xtal_ready_o(xr));

	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic logic near(int a, int b, int t);
		return a - b <= t && b - a <= t;
	endfunction

	task automatic check(logic [31:0] seen, logic [31:0] want);
		compares++;
		if (seen !== want) begin
			n_mismatch++;
			$display("unexpected at %0t: seen %h want %h", $time, seen, want);
		end
	endtask

	task automatic end_sim();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// One classic cycle; a read notes its expected low byte and mask
	task automatic bus(logic w, logic [4:0] a, logic [7:0] d, logic [7:0] m);
		if (!w) begin
			exp_q.push_back(d);
			msk_q.push_back(m);
		end
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'h1;
		di <= {24'h0, d};
		// Only the watchdog ends a wait for the answer
		do begin
			@(posedge clk_i);
		end while (ack !== 1'b1);
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask

	always @(posedge clk_i) begin
		logic [7:0] m;
		if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
			m = msk_q.pop_front();
			check({24'h0, dout[7:0] & m}, {24'h0, exp_q.pop_front() & m});
		end
	end

	// Rising edges of reference, system, bus and reference copy over a window
	task automatic rate();
		logic [4:0] p = 5'h00;
		{nr, ns, nb, ni, ne} = 160'h0;
		repeat (4000) begin
			@(posedge clk_i);
			nr += int'(ic && !p[3]);
			ns += int'(sc && !p[2]);
			nb += int'(bc && !p[1]);
			ni += int'(ir && !p[0]);
			ne += int'(er && !p[4]);
			p = {er, ic, sc, bc, ir};
		end
	endtask

	initial begin
		repeat (60000) @(posedge clk_i);
		n_mismatch++;
		end_sim();
	end

	initial begin
		{rst_b_i, cyc, stb, we, stop, adr, di} = '0;
		sel = 4'h1;
		repeat (4) @(posedge clk_i);
		rst_b_i <= 1'b1;
		@(posedge clk_i);
		bus(1'b0, ADDR_CTRL_ONE, CTRL_ONE_RST, 8'hff);
		bus(1'b0, ADDR_CTRL_TWO, CTRL_TWO_RST, 8'hff);
		bus(1'b0, ADDR_TRIM, TRIM_RST, 8'hff);
		bus(1'b0, ADDR_STAT_FT, {7'h0, FT_RST}, 8'hff);
		bus(1'b0, ADDR_LOOP_STAT, {4'h0, FCS_FEI, 1'b0}, 8'hfe);
		bus(1'b0, 5'h14, 8'h00, 8'hff);
		$display("test reset done");
		for (int i = 0; i < 4; i++) begin
			v = xs();
			bus(1'b1, ADDR_TRIM, v[7:0], 8'h0);
			bus(1'b1, ADDR_STAT_FT, v[15:8], 8'h0);
			bus(1'b0, ADDR_TRIM, v[7:0], 8'hff);
			bus(1'b0, ADDR_STAT_FT, {7'h0, v[8]}, 8'hf1);
			check({23'h0, trim}, {23'h0, v[7:0], v[8]});
		end
		$display("test trim done");
		for (int i = 0; i < 7; i++) begin
			bus(1'b1, ADDR_CTRL_TWO, c2[i], 8'h0);
			bus(1'b1, ADDR_CTRL_ONE, c1[i], 8'h0);
			repeat (300) @(posedge clk_i);
			bus(1'b0, ADDR_STAT_FT, {4'h0, sr[i], 2'h0}, 8'h0c);
			bus(1'b0, ADDR_LOOP_STAT, {4'h0, md[i], 1'b0}, 8'h0e);
			check({31'h0, le}, {31'h0, !c2[i][3]});
		end
		$display("test modes done");
		bus(1'b1, ADDR_CTRL_ONE, 8'h44, 8'h0);
		for (int b = 0; b < 4; b++) begin
			bus(1'b1, ADDR_CTRL_TWO, {b[1:0], 6'h02}, 8'h0);
			rate();
			check({31'h0, near(ns << b, nr, 2 << b)}, 32'h1);
			check({31'h0, near(nb * 2, ns, 3)}, 32'h1);
			check(ni, 32'h0);
		end
		bus(1'b1, ADDR_CTRL_ONE, 8'h46, 8'h0);
		rate();
		check({31'h0, near(ni, nr, 2)}, 32'h1);
		$display("test dividers done");
		bus(1'b1, ADDR_CTRL_TWO, 8'h43, 8'h0);
		bus(1'b1, ADDR_CTRL_ONE, 8'h45, 8'h0);
		for (int k = 0; k < 2; k++) begin
			stop <= 1'b1;
			repeat (100) @(posedge clk_i);
			rate();
			check({30'h0, ie, ee}, {30'h0, k == 0, k == 0});
			check({29'h0, le, sc, lk}, 32'h0);
			check({31'h0, ne > 40}, {31'h0, k == 0});
			check(ns, 32'h0);
			bus(1'b0, ADDR_LOOP_STAT, {4'h0, FCS_STOP, 1'b0}, 8'h0e);
			stop <= 1'b0;
			bus(1'b1, ADDR_CTRL_TWO, 8'h42, 8'h0);
			bus(1'b1, ADDR_CTRL_ONE, 8'h44, 8'h0);
			repeat (300) @(posedge clk_i);
		end
		$display("test stop done");
		v = xs();
		bus(1'b1, ADDR_CTRL_TWO, {2'h1, v[1:0], 4'h7}, 8'h0);
		repeat (1500) @(posedge clk_i);
		check({27'h0, p_rng, p_hgo, p_ext_ref_type_select, p_eren, p_erst}, {27'h0, v[1:0], 3'h7});
		bus(1'b0, ADDR_STAT_FT, 8'h02, 8'h02);
		bus(1'b1, ADDR_CTRL_TWO, 8'h43, 8'h0);
		bus(1'b0, ADDR_STAT_FT, 8'h00, 8'h02);
		$display("test crystal done");
		repeat (4) @(posedge clk_i);
		end_sim();
	end
endmodule
